/* File: logic/xcvr_guard_pkg.sv */
// Constants, types and register map of the transceiver mode guard
// Function
// - Mode comes from silent-select and, on enable variant, the enable input.
// - Low transmit-data turns the dominant driver on; high leaves bus recessive.
// - Receive output is low while bus dominant, high while bus recessive.
// - Normal mode sends transmit bits to bus and returns bus state.
// - Silent mode keeps driver off, bus recessive whatever transmit-data does.
// - Silent mode still forwards bus state while controller transmission is blocked.
// - Silent mode: another node's dominant drives receive output low.
// - Off mode disables the whole transceiver.
// - Off mode releases bus lines to high impedance.
// - Over-temperature indication turns the bus driver off.
// - During thermal shutdown everything except the driver keeps working.
// - Thermal off clears only when over-temperature gone and transmit-data high.
// - Dominant timer starts on each falling edge of transmit-data.
// - Transmit-data low beyond timeout disables driver, bus returns recessive.
// - Rising transmit-data edge resets the timer and clears its disable.
// - Timeout long enough for the lowest usable bit rate.
// - Open transmit-data defaults high; open select and enable default low.
// - Supply loss floats bus lines and receive output.
package xcvr_guard_pkg;

  // Clock and dominant timeout
  localparam int CLK_MHZ     = 250;
  localparam int TDOM_NS     = 1500000;
  localparam int DOM_CYC_DEF = TDOM_NS / 1000 * CLK_MHZ;

  // Register bus widths
  localparam int AW = 8;
  localparam int DW = 32;

  // Register offsets
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_MASK   = 8'h08;
  localparam logic [AW-1:0] OFS_STATE  = 8'h0C;
  localparam logic [AW-1:0] OFS_TOCNT  = 8'h10;

  // Control fields
  localparam int CTRL_FORCE_SILENT = 0;
  localparam int CTRL_USE_EN       = 1;
  localparam logic [1:0] CTRL_RST  = 2'h2;

  // Event bits, shared by status and mask
  localparam int EV_THERM  = 0;
  localparam int EV_DOM    = 1;
  localparam int EV_SUPPLY = 2;
  localparam int EV_MODE   = 3;
  localparam int EVW       = 4;

  // Fail-safe levels of open inputs
  localparam logic TX_OPEN_LVL  = 1'b1;
  localparam logic SEL_OPEN_LVL = 1'b0;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_SILENT,
    MODE_NORMAL
  } mode_t;

  // Register bus request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } reg_req_t;

  // Controller-side pins: value and open-pin indication
  typedef struct packed {
    logic tx_data;
    logic silent_sel;
    logic enable;
  } ctl_pins_t;

  // Bus-side driver outputs
  typedef struct packed {
    logic drive_dom;
    logic oe;
  } bus_drv_t;

endpackage : xcvr_guard_pkg

/* File: logic/level_sync.sv */
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/10ps
module level_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t st;
  sync_st_t next_st;

  // First stage feeds only the second
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule : level_sync

/* File: logic/dom_timeout.sv */
// Dominant timeout counter on the synchronised transmit level
`timescale 1ns/10ps
module dom_timeout #(
  parameter int CYC = 375000,
  parameter int CW  = $clog2(CYC + 1)
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic tx_level,
  output logic      expired,
  output logic      fire
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          prev_tx;
    logic          expired;
    logic          fire;
  } to_st_t;

  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  to_st_t st;
  to_st_t next_st;

  // Count the low run, trip once at the limit
  always_comb begin
    next_st         = st;
    next_st.prev_tx = tx_level;
    next_st.fire    = 1'b0;
    if (st.prev_tx && !tx_level) begin
      next_st.cnt     = '0;
      next_st.expired = 1'b0;
    end else if (!st.prev_tx && tx_level) begin
      next_st.cnt     = '0;
      next_st.expired = 1'b0;
    end else if (!tx_level && !st.expired) begin
      if (st.cnt == LAST) begin
        next_st.expired = 1'b1;
        next_st.fire    = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '{cnt: '0, prev_tx: 1'b1, expired: 1'b0, fire: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.expired;
  assign fire    = st.fire;

endmodule : dom_timeout

/* File: logic/xcvr_guard.sv */
// Transceiver mode guard: mode select, driver gating, protection, registers
`timescale 1ns/10ps
module xcvr_guard #(
  parameter int DOM_CYC = xcvr_guard_pkg::DOM_CYC_DEF
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Controller-side pins
  input  xcvr_guard_pkg::ctl_pins_t       pins,
  input  xcvr_guard_pkg::ctl_pins_t       pins_open,
  output logic                            rx_data,
  output logic                            rx_data_oe,
  // Bus side
  input  wire logic                       bus_dominant,
  output xcvr_guard_pkg::bus_drv_t        bus_drv,
  // Monitors
  input  wire logic                       over_temp,
  input  wire logic                       supply_ok,
  // Register port
  input  xcvr_guard_pkg::reg_req_t        req,
  output logic [xcvr_guard_pkg::DW-1:0]   rdata,
  output logic                            irq
);

  import xcvr_guard_pkg::*;

  localparam int TCW = 8;

  // Whole block state
  typedef struct packed {
    logic            rx_data;
    logic            rx_oe;
    logic            drive_dom;
    logic            bus_oe;
    logic            therm_off;
    logic            prev_hot;
    logic            prev_supply;
    mode_t           mode;
    logic [1:0]      ctrl;
    logic [EVW-1:0]  status;
    logic [EVW-1:0]  mask;
    logic [TCW-1:0]  to_count;
    logic [DW-1:0]   rdata;
  } guard_st_t;

  guard_st_t st;
  guard_st_t next_st;

  ctl_pins_t raw_pins;
  ctl_pins_t sync_pins;
  logic      hot_sync;
  logic      dom_expired;
  logic      dom_fire;
  mode_t     mode_now;
  logic [EVW-1:0] events;

  // Pick mode from select inputs and control bits
  function automatic mode_t decode_mode(input logic sel, input logic en,
                                        input logic use_en, input logic force_sil);
    mode_t m;
    m = MODE_NORMAL;
    if (use_en && !en) begin
      m = MODE_OFF;
    end else if (sel || force_sil) begin
      m = MODE_SILENT;
    end
    return m;
  endfunction : decode_mode

  // Word read back at an offset
  function automatic logic [DW-1:0] read_word(input logic [AW-1:0] a, input guard_st_t s,
                                              input ctl_pins_t p, input logic hot);
    logic [DW-1:0] w;
    w = '0;
    case (a)
      OFS_CTRL: begin
        w[1:0] = s.ctrl;
      end
      OFS_STATUS: begin
        w[EVW-1:0] = s.status;
      end
      OFS_MASK: begin
        w[EVW-1:0] = s.mask;
      end
      OFS_STATE: begin
        w[1:0] = s.mode;
        w[2]   = s.therm_off;
        w[3]   = dom_expired;
        w[4]   = s.drive_dom;
        w[5]   = s.rx_data;
        w[6]   = p.tx_data;
        w[7]   = hot;
      end
      OFS_TOCNT: begin
        w[TCW-1:0] = s.to_count;
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction : read_word

  // Fail-safe levels replace inputs that are reported open
  always_comb begin
    raw_pins.tx_data    = pins_open.tx_data    ? TX_OPEN_LVL  : pins.tx_data;
    raw_pins.silent_sel = pins_open.silent_sel ? SEL_OPEN_LVL : pins.silent_sel;
    raw_pins.enable     = pins_open.enable     ? SEL_OPEN_LVL : pins.enable;
  end

  // Synchronise controller pins and temperature flag
  level_sync #(
    .W       (3),
    .RST_VAL ({TX_OPEN_LVL, SEL_OPEN_LVL, SEL_OPEN_LVL})
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (raw_pins),
    .q       (sync_pins)
  );

  level_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_hot_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (over_temp),
    .q       (hot_sync)
  );

  // Dominant run limit on the transmit level
  dom_timeout #(
    .CYC     (DOM_CYC)
  ) u_dom_timeout (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tx_level(sync_pins.tx_data),
    .expired (dom_expired),
    .fire    (dom_fire)
  );

  // Mode seen this cycle
  assign mode_now = decode_mode(sync_pins.silent_sel, sync_pins.enable,
                                st.ctrl[CTRL_USE_EN], st.ctrl[CTRL_FORCE_SILENT]);

  // Events that set sticky status bits
  always_comb begin
    events            = '0;
    events[EV_THERM]  = hot_sync && !st.prev_hot;
    events[EV_DOM]    = dom_fire;
    events[EV_SUPPLY] = st.prev_supply && !supply_ok;
    events[EV_MODE]   = (mode_now != st.mode);
  end

  // Next state of the whole block
  always_comb begin
    next_st             = st;
    next_st.prev_hot    = hot_sync;
    next_st.prev_supply = supply_ok;
    next_st.mode        = mode_now;

    // Thermal driver-off latch
    if (hot_sync) begin
      next_st.therm_off = 1'b1;
    end else if (sync_pins.tx_data) begin
      next_st.therm_off = 1'b0;
    end

    // Driver and bus line control
    next_st.drive_dom = 1'b0;
    next_st.bus_oe    = 1'b0;
    if (supply_ok) begin
      case (mode_now)
        MODE_NORMAL: begin
          next_st.bus_oe    = 1'b1;
          next_st.drive_dom = !sync_pins.tx_data
                              && !next_st.therm_off
                              && !dom_expired
                              && !dom_fire;
        end
        MODE_SILENT: begin
          next_st.bus_oe    = 1'b1;
          next_st.drive_dom = 1'b0;
        end
        MODE_OFF: begin
          next_st.bus_oe    = 1'b0;
        end
        default: begin
          next_st.bus_oe    = 1'b0;
        end
      endcase
    end

    // Receive path, unaffected by thermal or timeout state
    if (!supply_ok) begin
      next_st.rx_oe   = 1'b0;
      next_st.rx_data = 1'b1;
    end else if (mode_now == MODE_OFF) begin
      next_st.rx_oe   = 1'b0;
      next_st.rx_data = 1'b1;
    end else begin
      next_st.rx_oe   = 1'b1;
      next_st.rx_data = !bus_dominant;
    end

    // Timeout event counter, saturating
    if (dom_fire && st.to_count != {TCW{1'b1}}) begin
      next_st.to_count = st.to_count + TCW'(1);
    end

    // Register writes
    if (req.wr) begin
      case (req.addr)
        OFS_CTRL: begin
          next_st.ctrl = req.wdata[1:0];
        end
        OFS_STATUS: begin
          next_st.status = st.status & ~req.wdata[EVW-1:0];
        end
        OFS_MASK: begin
          next_st.mask = req.wdata[EVW-1:0];
        end
        OFS_TOCNT: begin
          next_st.to_count = '0;
        end
        default: begin
          next_st.ctrl = st.ctrl;
        end
      endcase
    end

    // New events win over a clear in the same cycle
    next_st.status = next_st.status | events;

    // Read data valid in the cycle after the strobe only
    next_st.rdata = req.rd ? read_word(req.addr, st, sync_pins, hot_sync) : '0;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '{rx_data: 1'b1, rx_oe: 1'b0, drive_dom: 1'b0, bus_oe: 1'b0,
              therm_off: 1'b0, prev_hot: 1'b0, prev_supply: 1'b0,
              mode: MODE_OFF, ctrl: CTRL_RST, status: '0, mask: '0,
              to_count: '0, rdata: '0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign rx_data           = st.rx_data;
  assign rx_data_oe        = st.rx_oe;
  assign bus_drv.drive_dom = st.drive_dom;
  assign bus_drv.oe        = st.bus_oe;
  assign rdata             = st.rdata;
  assign irq               = |(st.status & st.mask);

endmodule : xcvr_guard

/* File: verif/xcvr_guard_properties.sv */
// Port-level checks of the transceiver mode guard
`timescale 1ns/10ps
module xcvr_guard_properties #(
  parameter int DOM_CYC = 20
) (
  input wire logic                     ref_clk,
  input wire logic                     rst,
  input xcvr_guard_pkg::ctl_pins_t     pins,
  input xcvr_guard_pkg::ctl_pins_t     pins_open,
  input logic                          rx_data,
  input logic                          rx_data_oe,
  input wire logic                     bus_dominant,
  input xcvr_guard_pkg::bus_drv_t      bus_drv,
  input wire logic                     over_temp,
  input wire logic                     supply_ok,
  input xcvr_guard_pkg::reg_req_t      req,
  input logic [xcvr_guard_pkg::DW-1:0] rdata,
  input logic                          irq
);
  import xcvr_guard_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tx_eff;
  logic sel_eff;
  int   dom_run;
  // Pin levels after fail-safe substitution
  assign tx_eff  = pins.tx_data | pins_open.tx_data;
  assign sel_eff = pins.silent_sel & ~pins_open.silent_sel;
  // Length of the current dominant drive
  always_ff @(posedge ref_clk) begin
    if (rst || !bus_drv.drive_dom) dom_run <= 0;
    else dom_run <= dom_run + 1;
  end
  sequence s_hot;
    over_temp [*3];
  endsequence
  chk_drive_src: assert property (bus_drv.drive_dom |-> !$past(tx_eff, 3))
    else $error("driver on without low transmit level");
  chk_silent_quiet: assert property (bus_drv.drive_dom |-> !$past(sel_eff, 3))
    else $error("driver on in silent mode");
  chk_hot_off: assert property (s_hot |=> !bus_drv.drive_dom)
    else $error("driver on while hot");
  chk_rise_needs_high: assert property (
    $rose(bus_drv.drive_dom) |-> $past(tx_eff, 4))
    else $error("driver resumed without transmit edge");
  chk_dom_limit: assert property (dom_run <= DOM_CYC + 1)
    else $error("dominant drive exceeds timeout");
  chk_rx_follow: assert property (
    rx_data_oe && $past(rx_data_oe) |-> rx_data == !$past(bus_dominant))
    else $error("receive output does not follow bus");
  chk_off_quiet: assert property (!rx_data_oe |-> rx_data && !bus_drv.drive_dom)
    else $error("activity while disabled");
  chk_supply_float: assert property (!$past(supply_ok) |-> !rx_data_oe && !bus_drv.oe)
    else $error("outputs driven without supply");
  chk_read_quiet: assert property (|rdata |-> $past(req.rd))
    else $error("read data outside read cycle");
endmodule : xcvr_guard_properties

bind xcvr_guard xcvr_guard_properties #(.DOM_CYC(DOM_CYC)) u_props (
  .ref_clk(ref_clk), .rst(rst), .pins(pins), .pins_open(pins_open),
  .rx_data(rx_data), .rx_data_oe(rx_data_oe), .bus_dominant(bus_dominant),
  .bus_drv(bus_drv), .over_temp(over_temp), .supply_ok(supply_ok),
  .req(req), .rdata(rdata), .irq(irq));

/* File: verif/can_ctl_model.sv */
// Behavioural protocol controller driving the transceiver pins
`timescale 1ns/10ps
module can_ctl_model (
  input wire logic                 ref_clk,
  input wire logic                 tx_cmd,
  input wire logic                 sel_cmd,
  input wire logic                 en_cmd,
  output xcvr_guard_pkg::ctl_pins_t pins
);
  import xcvr_guard_pkg::*;
  // Levels change just after each edge, idle taken from the bench commands
  always @(posedge ref_clk) pins <= '{tx_cmd, sel_cmd, en_cmd};
endmodule : can_ctl_model

/* File: verif/can_transceiver_mode_guard_tb_top.sv */
// Self-checking bench of the transceiver mode guard
`timescale 1ns/10ps
module can_transceiver_mode_guard_tb_top;
  import xcvr_guard_pkg::*;
  localparam int DOM_CYC = 20;
  logic          ref_clk = 1'h0;
  logic          rst = 1'h1;
  logic          tx_cmd = 1'h1;
  logic          sel_cmd = 1'h0;
  logic          en_cmd = 1'h0;
  ctl_pins_t     pins;
  ctl_pins_t     pins_open = '0;
  logic          bus_dominant = 1'h0;
  logic          over_temp = 1'h0;
  logic          supply_ok = 1'h1;
  reg_req_t      req = '0;
  logic          rx_data;
  logic          rx_data_oe;
  logic          irq;
  bus_drv_t      bus_drv;
  logic [DW-1:0] rdata;
  logic [DW-1:0] rv;
  int            error_cnt = 0;
  int            n_compared = 0;
  int            cycles = 0;

  always #2 ref_clk = ~ref_clk;

  can_ctl_model u_ctl (.ref_clk(ref_clk), .tx_cmd(tx_cmd), .sel_cmd(sel_cmd),
    .en_cmd(en_cmd), .pins(pins));

  xcvr_guard #(.DOM_CYC(DOM_CYC)) DUT (
    .ref_clk(ref_clk), .rst(rst), .pins(pins), .pins_open(pins_open),
    .rx_data(rx_data), .rx_data_oe(rx_data_oe), .bus_dominant(bus_dominant),
    .bus_drv(bus_drv), .over_temp(over_temp), .supply_ok(supply_ok),
    .req(req), .rdata(rdata), .irq(irq));

  task automatic test_done;
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge ref_clk) req <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge ref_clk) req.rd <= 1'h0;
    #1 d = rdata;
  endtask : rd

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk) req <= '{a, d, 1'h1, 1'h0};
    @(posedge ref_clk) req.wr <= 1'h0;
  endtask : wr

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done;
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    cyc(2);
    chk(bus_drv.oe, 1'h0);
    chk(rx_data_oe, 1'h0);
    rd(OFS_CTRL, rv);
    chk(rv, 32'h2);
    rd(8'h20, rv);
    chk(rv, 32'h0);
    // Normal: transmit and receive both pass
    @(posedge ref_clk) en_cmd <= 1'h1;
    cyc(6);
    chk(bus_drv.oe, 1'h1);
    rd(OFS_STATE, rv);
    chk(rv[1:0], 2'h2);
    @(posedge ref_clk) tx_cmd <= 1'h0;
    cyc(6);
    chk(bus_drv.drive_dom, 1'h1);
    @(posedge ref_clk) bus_dominant <= 1'h1;
    cyc(2);
    chk(rx_data, 1'h0);
    @(posedge ref_clk) tx_cmd <= 1'h1;
    @(posedge ref_clk) bus_dominant <= 1'h0;
    cyc(4);
    chk(bus_drv.drive_dom, 1'h0);
    chk(rx_data, 1'h1);
    // Silent: transmit blocked, reception kept
    @(posedge ref_clk) sel_cmd <= 1'h1;
    cyc(6);
    @(posedge ref_clk) tx_cmd <= 1'h0;
    cyc(6);
    chk(bus_drv.drive_dom, 1'h0);
    chk(bus_drv.oe, 1'h1);
    @(posedge ref_clk) bus_dominant <= 1'h1;
    cyc(2);
    chk(rx_data, 1'h0);
    rd(OFS_STATE, rv);
    chk(rv[1:0], 2'h1);
    @(posedge ref_clk) tx_cmd <= 1'h1;
    @(posedge ref_clk) bus_dominant <= 1'h0;
    sel_cmd <= 1'h0;
    cyc(6);
    // Dominant timeout, then release by a rising edge
    @(posedge ref_clk) tx_cmd <= 1'h0;
    cyc(6);
    chk(bus_drv.drive_dom, 1'h1);
    cyc(DOM_CYC);
    chk(bus_drv.drive_dom, 1'h0);
    rd(OFS_STATUS, rv);
    chk(rv[EV_DOM], 1'h1);
    rd(OFS_TOCNT, rv);
    chk(rv, 32'h1);
    wr(OFS_TOCNT, 32'h0);
    rd(OFS_TOCNT, rv);
    chk(rv, 32'h0);
    chk(irq, 1'h0);
    wr(OFS_MASK, 32'h2);
    cyc(1);
    chk(irq, 1'h1);
    @(posedge ref_clk) tx_cmd <= 1'h1;
    cyc(6);
    @(posedge ref_clk) tx_cmd <= 1'h0;
    cyc(6);
    chk(bus_drv.drive_dom, 1'h1);
    @(posedge ref_clk) tx_cmd <= 1'h1;
    wr(OFS_STATUS, 32'hF);
    cyc(2);
    chk(irq, 1'h0);
    // Thermal shutdown
    @(posedge ref_clk) over_temp <= 1'h1;
    cyc(4);
    @(posedge ref_clk) tx_cmd <= 1'h0;
    cyc(6);
    chk(bus_drv.drive_dom, 1'h0);
    @(posedge ref_clk) bus_dominant <= 1'h1;
    cyc(2);
    chk(rx_data, 1'h0);
    @(posedge ref_clk) over_temp <= 1'h0;
    bus_dominant <= 1'h0;
    cyc(6);
    chk(bus_drv.drive_dom, 1'h0);
    @(posedge ref_clk) tx_cmd <= 1'h1;
    cyc(6);
    @(posedge ref_clk) tx_cmd <= 1'h0;
    cyc(6);
    chk(bus_drv.drive_dom, 1'h1);
    rd(OFS_STATUS, rv);
    chk(rv[EV_THERM], 1'h1);
    @(posedge ref_clk) tx_cmd <= 1'h1;
    cyc(6);
    // Open pins fall back to safe levels
    @(posedge ref_clk) pins_open <= 3'h4;
    @(posedge ref_clk) tx_cmd <= 1'h0;
    cyc(6);
    chk(bus_drv.drive_dom, 1'h0);
    @(posedge ref_clk) tx_cmd <= 1'h1;
    cyc(3);
    @(posedge ref_clk) pins_open <= 3'h1;
    cyc(6);
    chk(bus_drv.oe, 1'h0);
    @(posedge ref_clk) pins_open <= 3'h0;
    cyc(6);
    // Enable pin ignored, silent forced by control bits
    wr(OFS_CTRL, 32'h1);
    cyc(2);
    rd(OFS_STATE, rv);
    chk(rv[1:0], 2'h1);
    @(posedge ref_clk) en_cmd <= 1'h0;
    cyc(6);
    chk(bus_drv.oe, 1'h1);
    chk(rx_data_oe, 1'h1);
    // Supply loss floats the outputs
    @(posedge ref_clk) supply_ok <= 1'h0;
    cyc(3);
    chk(rx_data_oe, 1'h0);
    chk(bus_drv.oe, 1'h0);
    rd(OFS_STATUS, rv);
    chk(rv[EV_SUPPLY], 1'h1);
    test_done;
  end
endmodule : can_transceiver_mode_guard_tb_top
